//--- inc/jtp_regs.vh
// Constants for the test access port: instruction codes, state codes, widths
`ifndef JTP_REGS_VH
`define JTP_REGS_VH

`define JTP_IR_WIDTH 4
`define JTP_IR_EXTEST 4'h0
`define JTP_IR_INTEST 4'h1
`define JTP_IR_SAMPLE 4'h2
`define JTP_IR_ABORT 4'h8
`define JTP_IR_DPACC 4'hA
`define JTP_IR_APACC 4'hB
`define JTP_IR_IDCODE 4'hE
`define JTP_IR_BYPASS 4'hF
`define JTP_IR_CAPTURE 4'h1
`define JTP_IR_RESET 4'hE

`define JTP_ST_RESET 4'hF
`define JTP_ST_IDLE 4'hC
`define JTP_ST_SEL_DR 4'h7
`define JTP_ST_CAP_DR 4'h6
`define JTP_ST_SH_DR 4'h2
`define JTP_ST_EX1_DR 4'h1
`define JTP_ST_PAU_DR 4'h3
`define JTP_ST_EX2_DR 4'h0
`define JTP_ST_UPD_DR 4'h5
`define JTP_ST_SEL_IR 4'h4
`define JTP_ST_CAP_IR 4'hE
`define JTP_ST_SH_IR 4'hA
`define JTP_ST_EX1_IR 4'h9
`define JTP_ST_PAU_IR 4'hB
`define JTP_ST_EX2_IR 4'h8
`define JTP_ST_UPD_IR 4'hD

`define JTP_ID_WIDTH 32
`define JTP_BSC_WIDTH 8
`define JTP_SYNC_STAGES 2

`endif

//--- rtl/jtp_sync.v
// Two-stage synchroniser for the test port pins
`timescale 1ns/1ps
module jtp_sync #(
  parameter WIDTH = 4
) (
  input wire clk,
  input wire sys_rst,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  always @(posedge clk) begin
    if (sys_rst) begin
      meta_q <= {WIDTH{1'b1}};
      sync_q <= {WIDTH{1'b1}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // jtp_sync

//--- rtl/jtp_tap.v
// Test access port controller with instruction, bypass, ID and boundary chains
//
// Functional notes
// - State advances on test-clock rise using mode-select
// - Low test reset, once sampled, holds Test-Logic-Reset without test clock
// - Power-on reset also enters Test-Logic-Reset
// - Entering Test-Logic-Reset loads the ID instruction
// - Five high mode-select edges reach Test-Logic-Reset
// - Stopped test clock keeps all state
// - Data in sampled on rise, routed to chain
// - Data out undriven unless shifting
// - State picks chain kind; instruction picks data chain
// - Unimplemented instructions decode as bypass
// - External/internal test touch no chain
// - Capture loads chain; shift moves one bit
// - Update copies chain into parallel register
// - Pins default to test function, pull-ups on
// - Four-bit instruction chain with parallel stage
// - Code 1111 selects one-bit bypass
// - Code 1110 selects identification chain
`timescale 1ns/1ps
`include "jtp_regs.vh"
module jtp_tap #(
  parameter [`JTP_ID_WIDTH-1:0] ID_WORD = 32'h00000001, // Arbitrary ID value
  parameter BSC_WIDTH = `JTP_BSC_WIDTH
) (
  input wire clk,
  input wire sys_rst,
  input wire tck,
  input wire tms,
  input wire tdi,
  input wire trst_n,
  input wire [BSC_WIDTH-1:0] bsc_pins,
  output reg tdo_o,
  output reg tdo_oe,
  output wire tdo_pull_en,
  output wire tms_pull_en,
  output wire tdi_pull_en,
  output wire tck_pull_en,
  output wire trst_pull_en,
  output wire port_func_sel,
  output wire [`JTP_IR_WIDTH-1:0] cur_instr,
  output wire [3:0] tap_state,
  output wire [BSC_WIDTH-1:0] bsc_update,
  output wire ext_test_act,
  output wire int_test_act
);
  // Pin defaults: test function, all pull-ups on
  assign tdo_pull_en = 1'b1;
  assign tms_pull_en = 1'b1;
  assign tdi_pull_en = 1'b1;
  assign tck_pull_en = 1'b1;
  assign trst_pull_en = 1'b1;
  assign port_func_sel = 1'b1;

  //////////////////////////////////////////////////////////////////////////////
  // Pin sampling and test-clock edge finding
  wire [3:0] pins_s;
  jtp_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in({tck, tms, tdi, trst_n}),
    .sync_out(pins_s)
  );
  wire tck_s = pins_s[3];
  wire tms_s = pins_s[2];
  wire tdi_s = pins_s[1];
  wire trst_s_n = pins_s[0];
  reg tck_prev_q;
  always @(posedge clk) begin
    if (sys_rst) begin
      tck_prev_q <= 1'b1;
    end else begin
      tck_prev_q <= tck_s;
    end
  end
  // No edge while test clock stands still, so all state holds
  wire tck_rise = tck_s & ~tck_prev_q;
  wire tck_fall = ~tck_s & tck_prev_q;

  // Boundary pin values come from outside the clock domain
  wire [BSC_WIDTH-1:0] bsc_pins_s;
  jtp_sync #(
    .WIDTH(BSC_WIDTH)
  ) u_bsc_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(bsc_pins),
    .sync_out(bsc_pins_s)
  );

  //////////////////////////////////////////////////////////////////////////////
  // State machine
  reg [3:0] state_q;
  reg [3:0] state_d;
  assign tap_state = state_q;

  always @* begin
    state_d = state_q;
    case (state_q)
      `JTP_ST_RESET: state_d = tms_s ? `JTP_ST_RESET : `JTP_ST_IDLE;
      `JTP_ST_IDLE: state_d = tms_s ? `JTP_ST_SEL_DR : `JTP_ST_IDLE;
      `JTP_ST_SEL_DR: state_d = tms_s ? `JTP_ST_SEL_IR : `JTP_ST_CAP_DR;
      `JTP_ST_CAP_DR: state_d = tms_s ? `JTP_ST_EX1_DR : `JTP_ST_SH_DR;
      `JTP_ST_SH_DR: state_d = tms_s ? `JTP_ST_EX1_DR : `JTP_ST_SH_DR;
      `JTP_ST_EX1_DR: state_d = tms_s ? `JTP_ST_UPD_DR : `JTP_ST_PAU_DR;
      `JTP_ST_PAU_DR: state_d = tms_s ? `JTP_ST_EX2_DR : `JTP_ST_PAU_DR;
      `JTP_ST_EX2_DR: state_d = tms_s ? `JTP_ST_UPD_DR : `JTP_ST_SH_DR;
      `JTP_ST_UPD_DR: state_d = tms_s ? `JTP_ST_SEL_DR : `JTP_ST_IDLE;
      `JTP_ST_SEL_IR: state_d = tms_s ? `JTP_ST_RESET : `JTP_ST_CAP_IR;
      `JTP_ST_CAP_IR: state_d = tms_s ? `JTP_ST_EX1_IR : `JTP_ST_SH_IR;
      `JTP_ST_SH_IR: state_d = tms_s ? `JTP_ST_EX1_IR : `JTP_ST_SH_IR;
      `JTP_ST_EX1_IR: state_d = tms_s ? `JTP_ST_UPD_IR : `JTP_ST_PAU_IR;
      `JTP_ST_PAU_IR: state_d = tms_s ? `JTP_ST_EX2_IR : `JTP_ST_PAU_IR;
      `JTP_ST_EX2_IR: state_d = tms_s ? `JTP_ST_UPD_IR : `JTP_ST_SH_IR;
      `JTP_ST_UPD_IR: state_d = tms_s ? `JTP_ST_SEL_DR : `JTP_ST_IDLE;
      default: state_d = `JTP_ST_RESET;
    endcase
  end

  // Test reset is sampled, then acts at once regardless of test clock
  wire tap_reset = sys_rst | ~trst_s_n;
  wire adv = tck_rise;

  always @(posedge clk) begin
    if (tap_reset) begin
      state_q <= `JTP_ST_RESET;
    end else if (adv) begin
      state_q <= state_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Instruction chain and decode
  reg [`JTP_IR_WIDTH-1:0] ir_sh_q;
  reg [`JTP_IR_WIDTH-1:0] ir_q;
  assign cur_instr = ir_q;

  always @(posedge clk) begin
    if (tap_reset) begin
      ir_sh_q <= `JTP_IR_CAPTURE;
      ir_q <= `JTP_IR_RESET;
    end else if (adv) begin
      if (state_d == `JTP_ST_RESET) begin
        ir_q <= `JTP_IR_RESET;
      end
      case (state_q)
        `JTP_ST_CAP_IR: ir_sh_q <= `JTP_IR_CAPTURE;
        `JTP_ST_SH_IR: ir_sh_q <= {tdi_s, ir_sh_q[`JTP_IR_WIDTH-1:1]};
        `JTP_ST_UPD_IR: ir_q <= ir_sh_q;
        default: ir_sh_q <= ir_sh_q;
      endcase
    end
  end

  localparam [1:0] SEL_BYP = 2'h0;
  localparam [1:0] SEL_ID = 2'h1;
  localparam [1:0] SEL_BSC = 2'h2;
  localparam [1:0] SEL_NONE = 2'h3;
  reg [1:0] dsel;
  always @* begin
    case (ir_q)
      `JTP_IR_IDCODE: dsel = SEL_ID;
      `JTP_IR_SAMPLE: dsel = SEL_BSC;
      `JTP_IR_EXTEST: dsel = SEL_NONE;
      `JTP_IR_INTEST: dsel = SEL_NONE;
      default: dsel = SEL_BYP;
    endcase
  end
  assign ext_test_act = (ir_q == `JTP_IR_EXTEST);
  assign int_test_act = (ir_q == `JTP_IR_INTEST);

  //////////////////////////////////////////////////////////////////////////////
  // Data chains
  reg byp_q;
  reg [`JTP_ID_WIDTH-1:0] id_q;
  reg [BSC_WIDTH-1:0] bsc_sh_q;
  reg [BSC_WIDTH-1:0] bsc_upd_q;
  assign bsc_update = bsc_upd_q;

  always @(posedge clk) begin
    if (tap_reset) begin
      byp_q <= 1'b0;
      id_q <= {`JTP_ID_WIDTH{1'b0}};
      bsc_sh_q <= {BSC_WIDTH{1'b0}};
      bsc_upd_q <= {BSC_WIDTH{1'b0}};
    end else if (adv) begin
      case (state_q)
        `JTP_ST_CAP_DR: begin
          if (dsel == SEL_BYP) byp_q <= 1'b0;
          if (dsel == SEL_ID) id_q <= ID_WORD;
          if (dsel == SEL_BSC) bsc_sh_q <= bsc_pins_s;
        end
        `JTP_ST_SH_DR: begin
          if (dsel == SEL_BYP) byp_q <= tdi_s;
          if (dsel == SEL_ID) id_q <= {tdi_s, id_q[`JTP_ID_WIDTH-1:1]};
          if (dsel == SEL_BSC) bsc_sh_q <= {tdi_s, bsc_sh_q[BSC_WIDTH-1:1]};
        end
        `JTP_ST_UPD_DR: begin
          if (dsel == SEL_BSC) bsc_upd_q <= bsc_sh_q;
        end
        default: byp_q <= byp_q;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Data out, changed on falling test-clock edge
  reg so_bit;
  always @* begin
    if (state_q == `JTP_ST_SH_IR) begin
      so_bit = ir_sh_q[0];
    end else begin
      case (dsel)
        SEL_ID: so_bit = id_q[0];
        SEL_BSC: so_bit = bsc_sh_q[0];
        default: so_bit = byp_q;
      endcase
    end
  end
  wire shifting = (state_q == `JTP_ST_SH_IR) |
    ((state_q == `JTP_ST_SH_DR) & (dsel != SEL_NONE));

  always @(posedge clk) begin
    if (tap_reset) begin
      tdo_o <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo_o <= so_bit;
      tdo_oe <= shifting;
    end
  end
endmodule // jtp_tap

//--- tb/jtp_tap_chk.sv
// Concurrent checks on the test access port outputs
`timescale 1ns/1ps
`include "jtp_regs.vh"
module jtp_tap_chk #(
  parameter BSC_WIDTH = 8
) (
  input wire clk,
  input wire sys_rst,
  input wire tck,
  input wire tms,
  input wire trst_n,
  input wire tdo_oe,
  input wire [`JTP_IR_WIDTH-1:0] cur_instr,
  input wire [3:0] tap_state,
  input wire [BSC_WIDTH-1:0] bsc_update,
  input wire ext_test_act,
  input wire int_test_act
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic tck_q;
  logic [2:0] ones_q;
  // Run of test clock rises with mode select high
  always @(posedge clk) begin
    tck_q <= tck;
    if (sys_rst) begin
      ones_q <= 3'h0;
    end else if (tck && !tck_q) begin
      ones_q <= !tms ? 3'h0 : (ones_q == 3'h7 ? ones_q : ones_q + 3'h1);
    end
  end
  rst_state_a: assert property ($fell(sys_rst) |-> tap_state == `JTP_ST_RESET &&
    cur_instr == `JTP_IR_IDCODE && !tdo_oe) else $error("bad state after reset");
  trst_hold_a: assert property (!trst_n [*5] |-> tap_state == `JTP_ST_RESET)
    else $error("test reset ignored");
  tck_still_a: assert property ((trst_n && $stable(tck)) [*8] |->
    $stable(tap_state) && $stable(cur_instr)) else $error("state moved without clock");
  reset_instr_a: assert property (tap_state == `JTP_ST_RESET [*2] |->
    cur_instr == `JTP_IR_IDCODE) else $error("reset instruction missing");
  oe_shift_a: assert property (tdo_oe |-> tap_state inside {`JTP_ST_SH_DR,
    `JTP_ST_EX1_DR, `JTP_ST_SH_IR, `JTP_ST_EX1_IR}) else $error("data out driven idle");
  ext_quiet_a: assert property (ext_test_act || int_test_act |-> $stable(bsc_update))
    else $error("chain updated in test mode");
  upd_only_a: assert property (!$stable(bsc_update) && tap_state != `JTP_ST_RESET |->
    $past(tap_state) == `JTP_ST_UPD_DR) else $error("update outside update state");
  oe_reset_a: assert property (tap_state == `JTP_ST_RESET |-> !tdo_oe)
    else $error("data out driven in reset state");
  five_tms_a: assert property (ones_q >= 3'h5 |-> ##[0:4] tap_state == `JTP_ST_RESET)
    else $error("five high mode selects ignored");
  cover property (tap_state == `JTP_ST_SH_IR);
  cover property (tap_state == `JTP_ST_SH_DR && tdo_oe);
  cover property (ext_test_act && tap_state == `JTP_ST_SH_DR);
endmodule // jtp_tap_chk
bind jtp_tap jtp_tap_chk #(.BSC_WIDTH(BSC_WIDTH)) chk_i (.*);

//--- tb/jtp_host.sv
// Host model driving the test port pins and sampling data out
`timescale 1ns/1ps
module jtp_host (
  input wire clk,
  input wire tdo_o,
  input wire tdo_oe,
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic vld,
  output logic seen
);
  wire tdo_pin = tdo_oe ? tdo_o : 1'b1;
  initial begin
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b1;
    vld = 1'b0;
    seen = 1'b0;
  end
  // One 800 ns period; clock then rests high
  task automatic cyc(input logic m, input logic d, input logic chk);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge clk);
    tck <= 1'b1;
    repeat (3) @(posedge clk);
    seen <= tdo_pin;
    vld <= chk;
    @(posedge clk);
    vld <= 1'b0;
  endtask
endmodule // jtp_host

//--- tb/jtag_tap_controller_tb_top.sv
// Self-checking bench for the test access port
`timescale 1ns/1ps
`include "jtp_regs.vh"
module jtag_tap_controller_tb_top;
  localparam logic [31:0] ID_V = 32'h5A3C0F96; // Arbitrary value
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic trst_n = 1'b1;
  logic [7:0] bsc_pins = 8'h00;
  wire tck, tms, tdi, vld, seen, tdo_o, tdo_oe, ext_a, int_a;
  wire [5:0] pin_def;
  wire [3:0] cur_instr, tap_state;
  wire [7:0] bsc_update;
  int err_total = 0;
  int samples_checked = 0;
  logic exp_q [$];
  logic [31:0] r;
  logic [3:0] byp [5] = '{4'hF, 4'h8, 4'hA, 4'hB, 4'h3};
  always #50 clk = ~clk;
  jtp_host host (.clk(clk), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .tck(tck), .tms(tms),
    .tdi(tdi), .vld(vld), .seen(seen));
  jtp_tap #(.ID_WORD(ID_V)) dut (.clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms),
    .tdi(tdi), .trst_n(trst_n), .bsc_pins(bsc_pins), .tdo_o(tdo_o), .tdo_oe(tdo_oe),
    .tdo_pull_en(pin_def[5]), .tms_pull_en(pin_def[4]), .tdi_pull_en(pin_def[3]),
    .tck_pull_en(pin_def[2]), .trst_pull_en(pin_def[1]),
    .port_func_sel(pin_def[0]), .cur_instr(cur_instr), .tap_state(tap_state),
    .bsc_update(bsc_update), .ext_test_act(ext_a), .int_test_act(int_a));
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic report_and_stop;
    $display("Checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    if (vld === 1'b1) begin
      if (exp_q.size() == 0) check("tdo extra", 1, 0);
      else check("tdo", seen, exp_q.pop_front());
    end
  end
  task automatic walk(input logic [7:0] ms, input int n);
    for (int i = 0; i < n; i++) host.cyc(ms[i], 1'b0, 1'b0);
  endtask
  // Shifts n bits, leaves by Exit1 and Update, ends in idle
  task automatic shift(input int n, input logic [31:0] d, input logic [31:0] e, input logic c);
    for (int i = 0; i < n; i++) begin
      if (c) exp_q.push_back(e[i]);
      host.cyc(i == n - 1, d[i], c);
    end
    walk(8'h01, 2);
    repeat (4) @(posedge clk);
  endtask
  task automatic load_ir(input logic [3:0] c);
    walk(8'h03, 4);
    shift(4, {28'h0, c}, 32'h1, 1'b1);
  endtask
  initial begin
    r = $urandom(32'hCF337192);
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    check("state", tap_state, `JTP_ST_RESET);
    check("instr", cur_instr, `JTP_IR_IDCODE);
    check("oe", tdo_oe, 1'b0);
    check("pins", pin_def, 6'h3F);
    walk(8'h02, 4);
    shift(32, 32'h0, ID_V, 1'b1);
    foreach (byp[k]) begin
      load_ir(byp[k]);
      check("instr", cur_instr, byp[k]);
      r = $urandom;
      walk(8'h01, 3);
      shift(32, r, {r[30:0], 1'b0}, 1'b1);
    end
    bsc_pins <= 8'($urandom);
    load_ir(4'h2);
    walk(8'h01, 3);
    r = $urandom;
    shift(8, r, {24'h0, bsc_pins}, 1'b1);
    check("update", bsc_update, r[7:0]);
    load_ir(4'h0);
    check("ext", ext_a, 1'b1);
    walk(8'h01, 3);
    shift(8, ~r, 32'hFF, 1'b1);
    check("update", bsc_update, r[7:0]);
    load_ir(4'h1);
    check("int", {ext_a, int_a}, 2'h1);
    walk(8'h01, 3);
    shift(8, r, 32'hFF, 1'b1);
    check("update", bsc_update, r[7:0]);
    walk(8'h1F, 5);
    repeat (4) @(posedge clk);
    check("state", tap_state, `JTP_ST_RESET);
    check("instr", cur_instr, `JTP_IR_IDCODE);
    walk(8'h02, 4);
    repeat (40) @(posedge clk);
    check("state", tap_state, `JTP_ST_SH_DR);
    walk(8'h03, 3);
    trst_n <= 1'b0;
    repeat (5) @(posedge clk);
    check("state", tap_state, `JTP_ST_RESET);
    trst_n <= 1'b1;
    check("queue", exp_q.size(), 0);
    report_and_stop;
  end
endmodule // jtag_tap_controller_tb_top
